/* hw/irq_ctrl_pkg.sv */
// package: register map, field layout, types and helpers of the interrupt controller
//------------------------------------------------------------
// Summary of operation
// RL1 - edge field: off, rising, falling, both edges
// RL2 - pin 3..0 fields at bits 7:6..1:0
// RL3 - global enable low blocks every interrupt
// RL4 - flags always set; vector needs enable
// RL5 - push next address, load vector, fetch
// RL6 - return instruction pops the saved address
// RL7 - taking an interrupt clears global enable
// RL8 - blocked requests still latch their flags
// RL9 - software re-enables globally for nesting
// RL10 - no acknowledge while return stack full
// RL11 - simultaneous requests served by fixed priority
// RL12 - any flag rising wakes from sleep
// RL13 - timer sources share three group vectors
// RL14 - timer register: A flag 5, P 4, enables 1,0
// RL15 - third control: flags 7:4, enables 3:0
// RL16 - unimplemented bits read as zero
// RL17 - service clears group flag, not timer flags
// RL18 - service clears individually vectored flag
// RL19 - timer vector needs global, timer, group enables
// RL20 - vectors and priority order are parameters
//------------------------------------------------------------
package irq_ctrl_pkg;
   localparam int unsigned NSRC  = 13;  // individually vectored sources
   localparam int unsigned VEC_W = 12;  // program counter width
   localparam int unsigned NGRP  = 3;   // timer groups
   // register byte addresses
   localparam logic [7:0] OFS_EDGE = 8'h00;
   localparam logic [7:0] OFS_CTL0 = 8'h04;
   localparam logic [7:0] OFS_CTL1 = 8'h08;
   localparam logic [7:0] OFS_CTL2 = 8'h0c;
   localparam logic [7:0] OFS_CTL3 = 8'h10;
   localparam logic [7:0] OFS_GRP0 = 8'h14;
   localparam logic [7:0] OFS_GRP1 = 8'h18;
   localparam logic [7:0] OFS_GRP2 = 8'h1c;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // field positions
   localparam int unsigned GLB_EN_BIT  = 0;
   localparam int unsigned C0_EN_LSB   = 1;
   localparam int unsigned C0_FLAG_LSB = 4;
   localparam int unsigned NIB_EN_LSB  = 0;
   localparam int unsigned NIB_FLAG_LSB = 4;
   localparam int unsigned TM_EN_LSB   = 0;  // P enable, A enable above it
   localparam int unsigned TM_FLAG_LSB = 4;  // P flag, A flag above it
   // source indices, laid out so register fields map onto contiguous ranges
   localparam int unsigned SRC_EXT0 = 0;
   localparam int unsigned SRC_EXT1 = 1;
   localparam int unsigned SRC_GRP0 = 2;
   localparam int unsigned SRC_GRP1 = 3;
   localparam int unsigned SRC_GRP2 = 4;
   localparam int unsigned SRC_ADC  = 5;
   localparam int unsigned SRC_SER  = 6;
   localparam int unsigned SRC_TB0  = 7;
   localparam int unsigned SRC_TB1  = 8;
   localparam int unsigned SRC_LVD  = 9;
   localparam int unsigned SRC_EEP  = 10;
   localparam int unsigned SRC_EXT2 = 11;
   localparam int unsigned SRC_EXT3 = 12;
   // edge select encodings
   localparam logic [1:0] EDGE_OFF  = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;

   typedef logic [NSRC-1:0] src_vec_t;

   // one-cycle event pulses from the peripherals
   typedef struct packed {
      logic            adc_done;
      logic            serial;
      logic            eeprom;
      logic            low_supply;
      logic [1:0]      tick;
      logic [NGRP-1:0] cmpa;
      logic [NGRP-1:0] cmpp;
   } periph_evt_t;

   // entry request handed to the core
   typedef struct packed {
      logic             push;
      logic             load;
      logic [VEC_W-1:0] vector;
   } irq_entry_t;

   // edge detection for one pin
   function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                     input logic now);
      logic rise;
      logic fall;
      rise = now & ~prev;
      fall = prev & ~now;
      case (sel)
         EDGE_OFF:  edge_hit = 1'b0;               // see RL1
         EDGE_RISE: edge_hit = rise;               // see RL1
         EDGE_FALL: edge_hit = fall;               // see RL1
         default:   edge_hit = rise | fall;        // see RL1
      endcase
   endfunction
endpackage

/* hw/irq_pin_edge.sv */
// module: edge detector for one external request pin
`timescale 1ns/100ps
module irq_pin_edge
   import irq_ctrl_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       pin_i,
   input  wire logic [1:0] sel_i,
   output logic            hit_o
);
   logic prev_q;
   logic prev_d;
   logic seen_q;
   logic seen_d;

   //------------------------------------------------------------
   // previous level
   //------------------------------------------------------------
   // first sample after reset only primes the history, so a pin that is
   // already high when reset ends does not look like a rising edge
   always_comb begin
      prev_d = pin_i;
      seen_d = 1'b1;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         seen_q <= seen_d;
      end
   end

   // pulse in the cycle the selected transition shows
   assign hit_o = seen_q & edge_hit(sel_i, prev_q, pin_i);  // see RL1

endmodule // irq_pin_edge

/* hw/irq_ctrl.sv */
// module: interrupt controller with register file on APB
`timescale 1ns/100ps
module irq_ctrl
   import irq_ctrl_pkg::*;
#(
   // entry address per source index, arbitrary plain defaults
   parameter logic [NSRC-1:0][VEC_W-1:0] VEC_ADDR = {
      12'h034, 12'h030, 12'h02c, 12'h028, 12'h024, 12'h020, 12'h01c,
      12'h018, 12'h014, 12'h010, 12'h00c, 12'h008, 12'h004},
   // source index per rank, rank 0 wins
   parameter logic [NSRC-1:0][3:0] PRIO_ORDER = {
      4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6,
      4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0}
)(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // event sources
   input  wire logic [3:0]  external_request_pins_i,
   input  periph_evt_t      evt_i,
   // core side
   input  wire logic        insn_boundary_i,
   input  wire logic        stack_full_i,
   input  wire logic        return_from_interrupt_i,
   output irq_entry_t       entry_o,
   output logic             pc_pop_o,
   output logic             irq_pending_o,
   output logic             wake_o
);
   typedef enum logic [0:0] {ST_IDLE, ST_ENTER} ent_state_t;

   // register state
   logic [7:0]            edge_sel_q, edge_sel_d;
   logic                  global_irq_enable_q, global_irq_enable_d;
   src_vec_t              flag_q, flag_d;
   src_vec_t              en_q, en_d;
   logic [NGRP-1:0][1:0]  tm_flag_q, tm_flag_d;   // [g][1]=A, [g][0]=P
   logic [NGRP-1:0][1:0]  tm_en_q, tm_en_d;
   // bus
   logic [31:0]           rdata_q, rdata_d;
   // entry sequencing
   ent_state_t            state_q, state_d;
   irq_entry_t            entry_q, entry_d;
   logic                  pop_q, pop_d;
   logic                  wake_q, wake_d;

   logic [3:0]            ext_hit;
   src_vec_t              set_vec;
   logic [NGRP-1:0][1:0]  tm_set;
   src_vec_t              eligible;
   logic                  req;
   logic                  take;
   logic [3:0]            win;
   src_vec_t              svc_clr;
   logic                  acc;
   logic                  hit;
   logic                  wr;
   logic [7:0]            wbyte;

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   // true when the address names a register
   function automatic logic addr_hit(input logic [7:0] a);
      case (a)
         OFS_EDGE, OFS_CTL0, OFS_CTL1, OFS_CTL2, OFS_CTL3,
         OFS_GRP0, OFS_GRP1, OFS_GRP2: addr_hit = 1'b1;
         default:                      addr_hit = 1'b0;
      endcase
   endfunction

   // highest ranked eligible source
   function automatic logic [3:0] pick(input src_vec_t el);
      logic [3:0] idx;
      pick = PRIO_ORDER[0];
      for (int r = NSRC - 1; r >= 0; r--) begin
         idx = PRIO_ORDER[r];
         if (el[idx]) begin
            pick = idx;                                   // see RL11
         end
      end
   endfunction

   // timer register image
   function automatic logic [7:0] tm_byte(input logic [1:0] f, input logic [1:0] e);
      tm_byte = 8'h00;                                    // see RL16
      tm_byte[TM_FLAG_LSB +: 2] = f;                      // see RL14
      tm_byte[TM_EN_LSB +: 2] = e;                        // see RL14
   endfunction

   //------------------------------------------------------------
   // external pin edge detectors
   //------------------------------------------------------------
   for (genvar p = 0; p < 4; p++) begin : g_pin
      irq_pin_edge u_edge (
         .clk_i   (clk_i),
         .rst_b_i (rst_b_i),
         .pin_i   (external_request_pins_i[p]),
         .sel_i   (edge_sel_q[2*p +: 2]),                 // see RL2
         .hit_o   (ext_hit[p])
      );
   end

   //------------------------------------------------------------
   // request sources and arbitration
   //------------------------------------------------------------
   // a group flag rises when one of its timer events arrives while that
   // timer's own enable is set
   always_comb begin
      for (int g = 0; g < NGRP; g++) begin
         tm_set[g] = {evt_i.cmpa[g], evt_i.cmpp[g]};
      end
      set_vec           = '0;
      set_vec[SRC_EXT0] = ext_hit[0];
      set_vec[SRC_EXT1] = ext_hit[1];
      set_vec[SRC_EXT2] = ext_hit[2];
      set_vec[SRC_EXT3] = ext_hit[3];
      set_vec[SRC_ADC]  = evt_i.adc_done;
      set_vec[SRC_SER]  = evt_i.serial;
      set_vec[SRC_TB0]  = evt_i.tick[0];
      set_vec[SRC_TB1]  = evt_i.tick[1];
      set_vec[SRC_LVD]  = evt_i.low_supply;
      set_vec[SRC_EEP]  = evt_i.eeprom;
      set_vec[SRC_GRP0] = |(tm_set[0] & tm_en_q[0]);      // see RL13
      set_vec[SRC_GRP1] = |(tm_set[1] & tm_en_q[1]);      // see RL13
      set_vec[SRC_GRP2] = |(tm_set[2] & tm_en_q[2]);      // see RL13
   end

   // group sources need their group enable as well, hence one mask
   assign eligible = flag_q & en_q & {NSRC{global_irq_enable_q}};  // see RL3, see RL4, see RL19
   assign req      = (|eligible) & ~stack_full_i;                  // see RL10
   assign win      = pick(eligible);
   assign take     = (state_q == ST_IDLE) & req & insn_boundary_i;

   // service clears only the winning vector flag; timer flags stay
   always_comb begin
      svc_clr = '0;
      if (take) begin
         svc_clr[win] = 1'b1;                             // see RL17, see RL18
      end
   end

   //------------------------------------------------------------
   // apb decode
   //------------------------------------------------------------
   assign acc       = psel_i & penable_i;
   assign hit       = addr_hit(paddr_i);
   assign wr        = acc & pwrite_i & hit & pstrb_i[0];
   assign wbyte     = pwdata_i[7:0];
   assign pready_o  = 1'b1;                    // zero wait states
   assign pslverr_o = acc & ~hit;              // unmapped address

   //------------------------------------------------------------
   // register file next state
   //------------------------------------------------------------
   // software writes first, then service clears, then hardware sets,
   // so an event in the clearing cycle is never lost
   always_comb begin
      edge_sel_d          = edge_sel_q;
      global_irq_enable_d = global_irq_enable_q;
      flag_d              = flag_q;
      en_d                = en_q;
      tm_flag_d           = tm_flag_q;
      tm_en_d             = tm_en_q;
      if (wr) begin
         case (paddr_i)
            OFS_EDGE: edge_sel_d = wbyte;                 // see RL2
            OFS_CTL0: begin
               global_irq_enable_d = wbyte[GLB_EN_BIT];   // see RL9
               flag_d[2:0] = wbyte[C0_FLAG_LSB +: 3];
               en_d[2:0]   = wbyte[C0_EN_LSB +: 3];
            end
            OFS_CTL1: begin
               flag_d[6:3] = wbyte[NIB_FLAG_LSB +: 4];
               en_d[6:3]   = wbyte[NIB_EN_LSB +: 4];
            end
            OFS_CTL2: begin
               flag_d[10:7] = wbyte[NIB_FLAG_LSB +: 4];   // see RL15
               en_d[10:7]   = wbyte[NIB_EN_LSB +: 4];     // see RL15
            end
            OFS_CTL3: begin
               flag_d[12:11] = wbyte[NIB_FLAG_LSB +: 2];
               en_d[12:11]   = wbyte[NIB_EN_LSB +: 2];
            end
            OFS_GRP0: begin
               tm_flag_d[0] = wbyte[TM_FLAG_LSB +: 2];    // see RL14
               tm_en_d[0]   = wbyte[TM_EN_LSB +: 2];
            end
            OFS_GRP1: begin
               tm_flag_d[1] = wbyte[TM_FLAG_LSB +: 2];
               tm_en_d[1]   = wbyte[TM_EN_LSB +: 2];
            end
            OFS_GRP2: begin
               tm_flag_d[2] = wbyte[TM_FLAG_LSB +: 2];
               tm_en_d[2]   = wbyte[TM_EN_LSB +: 2];
            end
            default: begin
               edge_sel_d = edge_sel_q;
            end
         endcase
      end
      if (take) begin
         global_irq_enable_d = 1'b0;                      // see RL7
      end
      flag_d = (flag_d & ~svc_clr) | set_vec;             // see RL4, see RL8
      for (int g = 0; g < NGRP; g++) begin
         tm_flag_d[g] = tm_flag_d[g] | tm_set[g];         // see RL4
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         edge_sel_q          <= RST_BYTE;
         global_irq_enable_q <= 1'b0;
         flag_q              <= '0;
         en_q                <= '0;
         tm_flag_q           <= '0;
         tm_en_q             <= '0;
      end else begin
         edge_sel_q          <= edge_sel_d;
         global_irq_enable_q <= global_irq_enable_d;
         flag_q              <= flag_d;
         en_q                <= en_d;
         tm_flag_q           <= tm_flag_d;
         tm_en_q             <= tm_en_d;
      end
   end

   //------------------------------------------------------------
   // read data
   //------------------------------------------------------------
   // captured in the setup cycle and shown through the access cycle
   always_comb begin
      rdata_d = rdata_q;
      if (psel_i && !penable_i) begin
         rdata_d = 32'h0000_0000;                         // see RL16
         case (paddr_i)
            OFS_EDGE: rdata_d[7:0] = edge_sel_q;
            OFS_CTL0: begin
               rdata_d[GLB_EN_BIT] = global_irq_enable_q;
               rdata_d[C0_FLAG_LSB +: 3] = flag_q[2:0];
               rdata_d[C0_EN_LSB +: 3]   = en_q[2:0];
            end
            OFS_CTL1: rdata_d[7:0] = {flag_q[6:3], en_q[6:3]};
            OFS_CTL2: rdata_d[7:0] = {flag_q[10:7], en_q[10:7]};     // see RL15
            OFS_CTL3: begin
               rdata_d[NIB_FLAG_LSB +: 2] = flag_q[12:11];
               rdata_d[NIB_EN_LSB +: 2]   = en_q[12:11];
            end
            OFS_GRP0: rdata_d[7:0] = tm_byte(tm_flag_q[0], tm_en_q[0]);
            OFS_GRP1: rdata_d[7:0] = tm_byte(tm_flag_q[1], tm_en_q[1]);
            OFS_GRP2: rdata_d[7:0] = tm_byte(tm_flag_q[2], tm_en_q[2]);
            default:  rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign prdata_o = rdata_q;

   //------------------------------------------------------------
   // entry sequencing toward the core
   //------------------------------------------------------------
   // one take per entry; the core pushes its next address on push and
   // jumps to vector on load, both one-cycle pulses
   always_comb begin
      state_d = state_q;
      entry_d = '0;
      case (state_q)
         ST_IDLE: begin
            if (take) begin
               entry_d.push   = 1'b1;                     // see RL5
               entry_d.load   = 1'b1;                     // see RL5
               entry_d.vector = VEC_ADDR[win];            // see RL5, see RL20
               state_d        = ST_ENTER;
            end
         end
         ST_ENTER: state_d = ST_IDLE;
         default:  state_d = ST_IDLE;
      endcase
   end

   // return restores the saved address; wake on any flag newly raised
   always_comb begin
      pop_d  = return_from_interrupt_i;                   // see RL6
      wake_d = (|(set_vec & ~flag_q)) |
               (|(tm_set & ~tm_flag_q));                  // see RL12
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
         entry_q <= '0;
         pop_q   <= 1'b0;
         wake_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         entry_q <= entry_d;
         pop_q   <= pop_d;
         wake_q  <= wake_d;
      end
   end

   assign entry_o       = entry_q;
   assign pc_pop_o      = pop_q;
   assign wake_o        = wake_q;
   assign irq_pending_o = req;

endmodule // irq_ctrl

/* verification/irq_ctrl_props.sv */
// checker: assertions on irq_ctrl ports
`timescale 1ns/100ps
module irq_ctrl_props
   import irq_ctrl_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   input  wire logic [31:0] prdata_o,
   input  wire logic        pready_o,
   input  wire logic        pslverr_o,
   input  wire logic [3:0]  external_request_pins_i,
   input  periph_evt_t      evt_i,
   input  wire logic        insn_boundary_i,
   input  wire logic        stack_full_i,
   input  wire logic        return_from_interrupt_i,
   input  irq_entry_t       entry_o,
   input  wire logic        pc_pop_o,
   input  wire logic        irq_pending_o,
   input  wire logic        wake_o
);
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // read setup, and a request the core can take
   sequence s_rd;
      psel_i && !penable_i && !pwrite_i;
   endsequence
   sequence s_take;
      irq_pending_o && insn_boundary_i && !entry_o.push;
   endsequence

   AST_TAKE: assert property (s_take |=> entry_o.push && entry_o.load)
      else $error("entry missing");
   AST_CAUSE: assert property (entry_o.push |-> $past(irq_pending_o && insn_boundary_i))
      else $error("entry unasked");
   AST_NO_BOUND: assert property (!insn_boundary_i |=> !entry_o.push)
      else $error("entry off boundary");
   AST_VEC_IDLE: assert property (!entry_o.load |-> !entry_o.push && entry_o.vector == '0)
      else $error("push without load");
   AST_GLB_CLR: assert property (entry_o.push |-> !irq_pending_o)
      else $error("pending in entry");
   AST_BLOCKED: assert property (entry_o.push && !(psel_i && pwrite_i) |=>
      !irq_pending_o)
      else $error("pending after entry");
   AST_FULL: assert property (stack_full_i |-> !irq_pending_o ##1 !entry_o.push)
      else $error("taken with stack full");
   AST_POP: assert property (return_from_interrupt_i |=> pc_pop_o)
      else $error("no pop after return");
   AST_POP_SRC: assert property (pc_pop_o |-> $past(return_from_interrupt_i))
      else $error("pop without return");
   AST_UNIMPL: assert property (s_rd ##1 penable_i |-> prdata_o[31:8] == 24'h0)
      else $error("upper bits set");
   AST_UNIMPL_C0: assert property (s_rd ##0 paddr_i == OFS_CTL0 |=> !prdata_o[7])
      else $error("ctl0 bit 7 set");
   AST_UNIMPL_TM: assert property (s_rd ##0 paddr_i >= OFS_CTL3 |=>
      prdata_o[7:6] == 2'h0 && prdata_o[3:2] == 2'h0)
      else $error("reserved bits set");
   AST_WAKE: assert property (wake_o |-> $past(evt_i) != '0 ||
      $past(external_request_pins_i) != $past(external_request_pins_i, 2))
      else $error("wake unasked");
endmodule // irq_ctrl_props

bind irq_ctrl irq_ctrl_props i_irq_ctrl_props (
   .clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
   .prdata_o, .pready_o, .pslverr_o, .external_request_pins_i, .evt_i, .insn_boundary_i,
   .stack_full_i, .return_from_interrupt_i, .entry_o, .pc_pop_o, .irq_pending_o, .wake_o
);

/* verification/cpu_core_model.sv */
// partner: behavioural cpu core with a small return stack
`timescale 1ns/100ps
module cpu_core_model
   import irq_ctrl_pkg::*;
#(
   parameter int DEPTH = 2
)(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        run_i,
   input  wire logic        ret_i,
   input  irq_entry_t       entry_i,
   input  wire logic        pop_i,
   output logic             boundary_o,
   output logic             full_o,
   output logic             ret_o,
   output int               depth_o,
   output int               taken_o,
   output logic [VEC_W-1:0] vec_o
);
   // stack depth and entry log
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         depth_o <= 0;
         taken_o <= 0;
         vec_o   <= '0;
      end else begin
         depth_o <= depth_o + int'(entry_i.push) - int'(pop_i);
         taken_o <= taken_o + int'(entry_i.push);
         if (entry_i.load)
            vec_o <= entry_i.vector;
      end
   end

   // boundary while running; return only with something stacked
   assign boundary_o = run_i;
   assign full_o     = (depth_o >= DEPTH);
   assign ret_o      = ret_i && (depth_o > 0);
endmodule // cpu_core_model

/* verification/irq_ctrl_bench.sv */
// testbench of irq_ctrl
`timescale 1ns/100ps
module irq_ctrl_bench
   import irq_ctrl_pkg::*;
;
   logic             clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic             pc_pop, pend, wake, boundary, full, ret, run, ret_req;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata;
   logic [3:0]       pstrb, pins;
   periph_evt_t      evt;
   irq_entry_t       entry;
   logic [VEC_W-1:0] vec;
   int               depth, taken;
   int               n_errors = 0;
   int               n_tests = 0;
   int               n_wake = 0;
   logic [7:0]       ofs [8] = '{OFS_EDGE, OFS_CTL0, OFS_CTL1, OFS_CTL2,
                                 OFS_CTL3, OFS_GRP0, OFS_GRP1, OFS_GRP2};
   logic [7:0]       msk [8] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'h33, 8'h33, 8'h33, 8'h33};

   irq_ctrl i_irq_ctrl (
      .clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .external_request_pins_i(pins), .evt_i(evt), .insn_boundary_i(boundary),
      .stack_full_i(full), .return_from_interrupt_i(ret), .entry_o(entry),
      .pc_pop_o(pc_pop), .irq_pending_o(pend), .wake_o(wake)
   );

   cpu_core_model #(.DEPTH(2)) i_cpu_core_model (
      .clk_i(clk), .rst_b_i(rst_b), .run_i(run), .ret_i(ret_req), .entry_i(entry),
      .pop_i(pc_pop), .boundary_o(boundary), .full_o(full), .ret_o(ret),
      .depth_o(depth), .taken_o(taken), .vec_o(vec)
   );

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      wrap_up();
   end

   // count wake pulses
   always @(posedge clk) begin
      if (wake === 1'b1)
         n_wake <= n_wake + 1;
   end

   //------------------------------
   // helpers
   //------------------------------
   task automatic wrap_up();
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q, output logic e);
      int n = 0;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) begin
         n_errors++;
         wrap_up();
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 8'h00, q, e);
      chk($sformatf("reg %h", a), q, {24'h0, x});
   endtask

   task automatic pulse(input periph_evt_t v);
      evt <= v;
      @(posedge clk);
      evt <= '0;
      @(posedge clk);
   endtask

   task automatic settle();
      repeat (3) @(posedge clk);
   endtask

   task automatic retire();
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // wait for entry t, check vector of source s
   task automatic take(input int t, input int s);
      int n = 0;
      while (taken < t && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk("entries", taken, t);
      chk("vector", {20'h0, vec}, 32'(4 + 4 * s));
   endtask

   //------------------------------
   // main sequence
   //------------------------------
   initial begin
      logic [31:0] q;
      logic        e;
      logic [7:0]  a, b;
      int          w;
      {rst_b, psel, penable, pwrite, run, ret_req} = '0;
      paddr  = '0;
      pwdata = '0;
      pins   = '0;
      evt    = '0;
      pstrb  = 4'hf;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      // reset, writable and reserved bits
      for (int i = 0; i < 8; i++) begin
         rd(ofs[i], 8'h00);
         wr(ofs[i], 8'hff);
         rd(ofs[i], msk[i]);
         wr(ofs[i], 8'h00);
      end
      apb(1'b0, 8'h20, 8'h00, q, e);
      chk("unmapped err", {31'h0, e}, 32'h1);
      chk("unmapped data", q, 32'h0);
      // every edge mode on every pin, rise then fall
      for (int p = 0; p < 4; p++) begin
         for (int m = 0; m < 4; m++) begin
            a = (p < 2) ? OFS_CTL0 : OFS_CTL3;
            b = 8'h10 << (p % 2);
            wr(OFS_EDGE, 8'(m << (2 * p)));
            pins[p] <= 1'b1;
            settle();
            rd(a, (m % 2 == 1) ? b : 8'h00);
            wr(a, 8'h00);
            pins[p] <= 1'b0;
            settle();
            rd(a, (m >= 2) ? b : 8'h00);
            wr(a, 8'h00);
         end
      end
      chk("wake count", n_wake, 16);
      // flag, enable, global enable, entry
      run <= 1'b1;
      pulse(12'h800);
      rd(OFS_CTL1, 8'h40);
      wr(OFS_CTL1, 8'h44);
      settle();
      chk("pending", {31'h0, pend}, 32'h0);
      wr(OFS_CTL0, 8'h01);
      take(1, SRC_ADC);
      rd(OFS_CTL0, 8'h00);
      rd(OFS_CTL1, 8'h04);
      retire();
      // two requests latched while blocked
      pulse(12'h440);
      wr(OFS_CTL1, 8'h88);
      wr(OFS_CTL2, 8'h11);
      rd(OFS_CTL1, 8'h88);
      wr(OFS_CTL0, 8'h01);
      take(2, SRC_SER);
      wr(OFS_CTL0, 8'h01);
      take(3, SRC_TB0);
      // full stack: request waits for a return
      pulse(12'h200);
      wr(OFS_CTL2, 8'h88);
      wr(OFS_CTL0, 8'h01);
      settle();
      chk("entries", taken, 3);
      chk("pending", {31'h0, pend}, 32'h0);
      retire();
      take(4, SRC_EEP);
      repeat (2) retire();
      chk("depth", depth, 0);
      // timer group: needs group enable, keeps timer flag
      wr(OFS_GRP1, 8'h02);
      pulse(12'h010);
      wr(OFS_CTL0, 8'h01);
      settle();
      chk("entries", taken, 4);
      wr(OFS_CTL1, 8'h11);
      take(5, SRC_GRP1);
      rd(OFS_GRP1, 8'h22);
      rd(OFS_CTL1, 8'h01);
      wr(OFS_GRP1, 8'h00);
      // a flag already set gives no second wake
      w = n_wake;
      pulse(12'h100);
      pulse(12'h100);
      settle();
      chk("wake count", n_wake - w, 1);
      wrap_up();
   end
endmodule // irq_ctrl_bench
